// *** pkg/qrvt_pkg.sv ***
// Constants, types and register map of the quasi-resonant turn-on controller
`default_nettype none
package qrvt_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RATE_LOW_HZ = 136_000;
  localparam int unsigned RATE_HIGH_HZ = 225_000;
  localparam int unsigned MASK_SHORT_NS = 2500;
  localparam int unsigned MASK_LONG_NS = 6300;
  localparam int unsigned SAMPLE_DELAY_NS = 1000;
  localparam int unsigned SAMPLE_WIN_NS = 200;
  localparam int unsigned TURNON_DELAY_NS = 150;

  localparam int unsigned CNT_W = 11;
  typedef logic [CNT_W-1:0] qrvt_cnt_t;

  // Least times round up to whole cycles, never below one
  function automatic qrvt_cnt_t qrvt_ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c == 0)
    begin
      c = 1;
    end
    return qrvt_cnt_t'(c);
  endfunction : qrvt_ns_to_cyc

  // Minimum period rounds up so the rate limit is never exceeded
  localparam qrvt_cnt_t PERIOD_LOW_CYC = qrvt_cnt_t'((CLK_HZ + RATE_LOW_HZ - 1) / RATE_LOW_HZ);
  localparam qrvt_cnt_t PERIOD_HIGH_CYC = qrvt_cnt_t'((CLK_HZ + RATE_HIGH_HZ - 1) / RATE_HIGH_HZ);
  localparam qrvt_cnt_t MASK_SHORT_CYC = qrvt_ns_to_cyc(MASK_SHORT_NS);
  localparam qrvt_cnt_t MASK_LONG_CYC = qrvt_ns_to_cyc(MASK_LONG_NS);
  localparam qrvt_cnt_t SAMPLE_DELAY_CYC = qrvt_ns_to_cyc(SAMPLE_DELAY_NS);
  localparam qrvt_cnt_t SAMPLE_WIN_CYC = qrvt_ns_to_cyc(SAMPLE_WIN_NS);
  localparam qrvt_cnt_t TURNON_DELAY_CYC = qrvt_ns_to_cyc(TURNON_DELAY_NS);

  // Start-up charge levels in microamps
  localparam logic [11:0] CHARGE_NORMAL_UA = 12'hBB8;
  localparam logic [11:0] CHARGE_REDUCED_UA = 12'h258;

  // Register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SKIP = 8'h08;
  localparam int unsigned CTRL_HIGH_RATE_BIT = 0;
  localparam int unsigned CTRL_FAULT_BIT = 1;
  localparam int unsigned ST_GATE_BIT = 4;
  localparam int unsigned ST_LONG_BIT = 5;
  localparam int unsigned ST_REDUCED_BIT = 6;
  localparam int unsigned ST_CHARGER_BIT = 7;
  localparam int unsigned ST_ARMED_BIT = 8;
  localparam logic CTRL_RESET = 1'b0;

  typedef enum logic [3:0] {
    ST_CHARGE = 4'h1,
    ST_RUN = 4'h2,
    ST_STOPPED = 4'h4,
    ST_HALT = 4'h8
  } qrvt_state_t;

  // Comparator decisions from the analogue front end, high when true
  typedef struct packed {
    logic supply_below_stop;
    logic supply_above_start;
    logic supply_below_restart;
    logic drain_above_start;
    logic sense_above_arm;
    logic sense_above_trig;
    logic sense_above_1v;
    logic peak_limit;
  } qrvt_cmp_t;

  // Commands to the high voltage start-up charger
  typedef struct packed {
    logic charger_en;
    logic charge_reduced;
    logic [11:0] charge_ua;
  } qrvt_charger_t;
endpackage : qrvt_pkg
`default_nettype wire

// *** design/qrvt_sync.sv ***
// Two-stage synchroniser for asynchronous comparator levels
`default_nettype none
module qrvt_sync
  import qrvt_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } qrvt_sync_st_t;

  qrvt_sync_st_t s_r;
  qrvt_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt.meta = async_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;
endmodule : qrvt_sync
`default_nettype wire

// *** design/qrvt_timer.sv ***
// Loadable down counter with expiry pulse
`default_nettype none
module qrvt_timer
  import qrvt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire qrvt_cnt_t load_val,
  // Status
  output logic done,
  output logic expire
);
  qrvt_cnt_t cnt_r;
  qrvt_cnt_t cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
    begin
      cnt_nxt = load_val;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - qrvt_cnt_t'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == '0);
  // Expiry reported in the last counting cycle, suppressed by a reload
  assign expire = (cnt_r == qrvt_cnt_t'(1)) && !load;
endmodule : qrvt_timer
`default_nettype wire

// *** design/qrvt_top.sv ***
// Turn-on timing and supply sequencing of a quasi-resonant flyback controller
//
// Overview of operation
// - Supply below stop level forces switch off
// - Drain low after stop: halt until drain returns high
// - Drain high: recharge once supply below restart
// - After fault use reduced charge current
// - Armed trigger fall turns on after delay
// - Trigger needs prior rising arm edge
// - Ignore sense edges during turn-off mask
// - Rate-limit oscillator, low or high variant
// - Late valid edge turns on, restarts oscillator
// - Early trigger discarded, switch stays off
// - After discard re-arm, skip further valleys
// - Turn-on in ST_RUN needs oscillator and mask expired
// - Mask time short or long value
// - Sample below 1V short, above long
// - Sample sense after delay past turn-off
// - Supply at start: switch, charger off
`default_nettype none
module qrvt_top
  import qrvt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analogue comparators, asynchronous
  input wire qrvt_cmp_t cmp_async,
  // Fault shutdown request from protection logic, same clock
  input wire logic fault_stop,
  // Power switch and start-up charger
  output logic gate_on,
  output qrvt_charger_t charger
);
  typedef struct packed {
    qrvt_state_t fsm;
    logic gate;
    logic armed;
    logic pend;
    logic fault_flag;
    logic blank_long;
    logic arm_prev;
    logic trig_prev;
    logic high_rate;
    logic sw_fault;
    logic ack;
    logic [31:0] dat;
    logic [15:0] skip;
    qrvt_charger_t chg;
  } qrvt_top_st_t;

  qrvt_top_st_t s_r;
  qrvt_top_st_t s_nxt;
  qrvt_cmp_t cmp;
  logic osc_done;
  logic mask_done;
  logic dly_expire;
  logic smp_expire;
  logic win_done;
  logic osc_load;
  logic mask_load;
  logic dly_load;
  qrvt_cnt_t osc_val;
  qrvt_cnt_t mask_val;

  function automatic qrvt_charger_t chg_cmd(input logic en, input logic reduced);
    qrvt_charger_t c;
    c.charger_en = en;
    c.charge_reduced = reduced;
    c.charge_ua = reduced ? CHARGE_REDUCED_UA : CHARGE_NORMAL_UA;
    return c;
  endfunction : chg_cmd

  qrvt_sync #(
    .W($bits(qrvt_cmp_t))
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(cmp_async),
    .sync_out(cmp)
  );

  // Rate-limit oscillator, restarted at every turn-on
  qrvt_timer u_osc (
    .clock(clock),
    .rst(rst),
    .load(osc_load),
    .load_val(osc_val),
    .done(osc_done),
    .expire()
  );

  qrvt_timer u_mask (
    .clock(clock),
    .rst(rst),
    .load(mask_load),
    .load_val(mask_val),
    .done(mask_done),
    .expire()
  );

  qrvt_timer u_dly (
    .clock(clock),
    .rst(rst),
    .load(dly_load),
    .load_val(TURNON_DELAY_CYC),
    .done(),
    .expire(dly_expire)
  );

  qrvt_timer u_smp (
    .clock(clock),
    .rst(rst),
    .load(mask_load),
    .load_val(SAMPLE_DELAY_CYC),
    .done(),
    .expire(smp_expire)
  );

  qrvt_timer u_win (
    .clock(clock),
    .rst(rst),
    .load(smp_expire),
    .load_val(SAMPLE_WIN_CYC),
    .done(win_done),
    .expire()
  );

  assign osc_val = s_r.high_rate ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
  assign mask_val = s_r.blank_long ? MASK_LONG_CYC : MASK_SHORT_CYC;

  always_comb
  begin
    logic arm_rise;
    logic trig_fall;
    logic turn_on;
    logic turn_off;
    logic quiet;
    logic bus_req;
    logic fault_now;
    arm_rise = 1'b0;
    trig_fall = 1'b0;
    turn_on = 1'b0;
    turn_off = 1'b0;
    quiet = 1'b0;
    bus_req = 1'b0;
    fault_now = 1'b0;
    s_nxt = s_r;
    s_nxt.arm_prev = cmp.sense_above_arm;
    s_nxt.trig_prev = cmp.sense_above_trig;
    s_nxt.sw_fault = 1'b0;
    arm_rise = cmp.sense_above_arm && !s_r.arm_prev;
    trig_fall = !cmp.sense_above_trig && s_r.trig_prev;
    fault_now = fault_stop || s_r.sw_fault;
    osc_load = 1'b0;
    mask_load = 1'b0;
    dly_load = 1'b0;

    case (s_r.fsm)
      ST_CHARGE:
      begin
        s_nxt.chg = chg_cmd(cmp.drain_above_start, s_r.fault_flag);
        if (cmp.supply_above_start && !cmp.supply_below_stop)
        begin
          // First pulse starts the cycle; edges then take over
          s_nxt.fsm = ST_RUN;
          s_nxt.chg = chg_cmd(1'b0, s_r.fault_flag);
          turn_on = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (cmp.supply_below_stop || fault_now)
        begin
          s_nxt.fsm = ST_STOPPED;
          turn_off = 1'b1;
          s_nxt.pend = 1'b0;
          s_nxt.armed = 1'b0;
          s_nxt.fault_flag = s_r.fault_flag || fault_now;
        end
        else if (s_r.gate)
        begin
          turn_off = cmp.peak_limit;
        end
        else if (s_r.pend)
        begin
          if (dly_expire)
          begin
            turn_on = 1'b1;
            s_nxt.pend = 1'b0;
            s_nxt.fault_flag = 1'b0;
            s_nxt.chg = chg_cmd(1'b0, 1'b0);
          end
        end
        else
        begin
          // Ringing right after turn-off must not arm or fire
          quiet = !mask_done;
          if (!quiet && arm_rise)
          begin
            s_nxt.armed = 1'b1;
          end
          if (!quiet && trig_fall && s_r.armed)
          begin
            s_nxt.armed = 1'b0;
            if (osc_done)
            begin
              dly_load = 1'b1;
              s_nxt.pend = 1'b1;
            end
            else
            begin
              s_nxt.skip = s_r.skip + 16'h0001;
            end
          end
        end
      end
      ST_STOPPED:
      begin
        if (!cmp.drain_above_start)
        begin
          s_nxt.fsm = ST_HALT;
        end
        else if (cmp.supply_below_restart)
        begin
          s_nxt.fsm = ST_CHARGE;
          s_nxt.chg = chg_cmd(1'b1, s_r.fault_flag);
        end
      end
      ST_HALT:
      begin
        // Power-down completes; only a returning drain voltage revives
        s_nxt.chg = chg_cmd(1'b0, s_r.fault_flag);
        if (cmp.drain_above_start)
        begin
          s_nxt.fsm = ST_STOPPED;
        end
      end
      default:
      begin
        s_nxt.fsm = ST_HALT;
        turn_off = 1'b1;
      end
    endcase

    if (turn_on)
    begin
      s_nxt.gate = 1'b1;
      osc_load = 1'b1;
      s_nxt.armed = 1'b0;
    end
    if (turn_off)
    begin
      s_nxt.gate = 1'b0;
      mask_load = 1'b1;
    end

    // Blanking choice is sampled each cycle of the strobe window
    if (!win_done && s_r.fsm == ST_RUN)
    begin
      s_nxt.blank_long = cmp.sense_above_1v;
    end

    // Bus: one wait state, ack dropped the cycle after it is given
    bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = bus_req;
    s_nxt.dat = '0;
    if (bus_req)
    begin
      case (wb_adr_i)
        ADR_CTRL:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            s_nxt.high_rate = wb_dat_i[CTRL_HIGH_RATE_BIT];
            s_nxt.sw_fault = wb_dat_i[CTRL_FAULT_BIT];
          end
          s_nxt.dat[CTRL_HIGH_RATE_BIT] = s_r.high_rate;
        end
        ADR_STATUS:
        begin
          s_nxt.dat[3:0] = s_r.fsm;
          s_nxt.dat[ST_GATE_BIT] = s_r.gate;
          s_nxt.dat[ST_LONG_BIT] = s_r.blank_long;
          s_nxt.dat[ST_REDUCED_BIT] = s_r.chg.charge_reduced;
          s_nxt.dat[ST_CHARGER_BIT] = s_r.chg.charger_en;
          s_nxt.dat[ST_ARMED_BIT] = s_r.armed;
        end
        ADR_SKIP:
        begin
          s_nxt.dat[15:0] = s_r.skip;
          if (wb_we_i && wb_sel_i[0])
          begin
            // A skip in the same cycle is counted, not lost
            s_nxt.skip = s_nxt.skip - s_r.skip;
          end
        end
        default:
        begin
          s_nxt.dat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '{fsm: ST_CHARGE, high_rate: CTRL_RESET, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign gate_on = s_r.gate;
  assign charger = s_r.chg;
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
endmodule : qrvt_top
`default_nettype wire

// *** verif/qrvt_monitor.sv ***
// Assertions on the turn-on controller top ports
`default_nettype none
module qrvt_monitor
  import qrvt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Front end and switch
  input wire qrvt_cmp_t cmp_async,
  input wire logic fault_stop,
  input wire logic gate_on,
  input wire qrvt_charger_t charger
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Cycles since turn-on and turn-off; saturated by a stop or charging, so restarts pass
  qrvt_cnt_t on_n_r;
  qrvt_cnt_t off_n_r;
  logic hr_r;
  logic gate_q_r;
  always_ff @(posedge clock)
  begin
    gate_q_r <= gate_on;
    if (rst || fault_stop || cmp_async.supply_below_stop || charger.charger_en)
    begin
      on_n_r <= '1;
      off_n_r <= '1;
    end
    else
    begin
      on_n_r <= (gate_on && !gate_q_r) ? 11'h001 : on_n_r + {10'h000, on_n_r != '1};
      off_n_r <= (!gate_on && gate_q_r) ? 11'h001 : off_n_r + {10'h000, off_n_r != '1};
    end
    if (rst)
      hr_r <= CTRL_RESET;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_CTRL && wb_sel_i[0])
      hr_r <= wb_dat_i[CTRL_HIGH_RATE_BIT];
  end
  property p_stop_off;
    cmp_async.supply_below_stop [*5] |-> !gate_on;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("gate on below stop");
  property p_sync_lat;
    $rose(cmp_async.supply_below_stop) && gate_on && !cmp_async.peak_limit |=> gate_on;
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("stop seen too early");
  property p_halt;
    (cmp_async.supply_below_stop && !cmp_async.drain_above_start) [*5] |-> !charger.charger_en;
  endproperty
  a_halt: assert property (p_halt) else $error("charger on with drain low");
  property p_level;
    charger.charger_en |->
      charger.charge_ua == (charger.charge_reduced ? CHARGE_REDUCED_UA : CHARGE_NORMAL_UA);
  endproperty
  a_level: assert property (p_level) else $error("wrong charge level");
  property p_run_chg;
    gate_on |-> !charger.charger_en;
  endproperty
  a_run_chg: assert property (p_run_chg) else $error("charger on while switching");
  property p_period;
    $rose(gate_on) |-> on_n_r >= (hr_r ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC);
  endproperty
  a_period: assert property (p_period) else $error("turn-on before period");
  property p_mask;
    $rose(gate_on) |-> off_n_r >= MASK_SHORT_CYC;
  endproperty
  a_mask: assert property (p_mask) else $error("turn-on inside mask");
  property p_reduced;
    $fell(charger.charge_reduced) |-> gate_on;
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced level dropped early");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
endmodule : qrvt_monitor
bind qrvt_top qrvt_monitor mon (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .cmp_async(cmp_async),
  .fault_stop(fault_stop), .gate_on(gate_on), .charger(charger));
`default_nettype wire

// *** verif/qrvt_frontend_model.sv ***
// Behavioural comparators and power switch facing the controller
`default_nettype none
module qrvt_frontend_model
  import qrvt_pkg::*;
(
  // Clock
  input wire logic clock,
  // Levels from the bench: stop, start, restart, drain
  input wire logic [3:0] lv,
  // On-time to current limit, ringing half period, sense above 1V
  input wire logic [10:0] on_cyc,
  input wire logic [10:0] ring_half,
  input wire logic s1v,
  // Switch command and comparator decisions
  input wire logic gate_on,
  output qrvt_cmp_t cmp
);
  logic [10:0] on_n_r = 11'h000;
  logic [11:0] off_n_r = 12'h000;
  logic [11:0] q;
  logic hi;
  always @(posedge clock)
  begin
    on_n_r <= (gate_on === 1'b1) ? on_n_r + 11'h001 : 11'h000;
    off_n_r <= (gate_on === 1'b1) ? 12'h000 : off_n_r + 12'h001;
  end
  // Demagnetisation plateau, then ringing that never damps out
  assign q = off_n_r / {1'b0, ring_half};
  assign hi = !gate_on && (off_n_r < 12'h12C || !q[0]);
  // Current limit holds until the switch is really off
  assign cmp = {lv, hi, hi, hi && s1v, gate_on && on_n_r >= on_cyc};
endmodule : qrvt_frontend_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the quasi-resonant turn-on controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qrvt_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic fault = 1'b0;
  logic [3:0] lv = 4'h1;
  logic [10:0] on_cyc = 11'h0C8;
  logic [10:0] ring_half = 11'h064;
  logic s1v = 1'b0;
  logic gate_on;
  qrvt_charger_t charger;
  qrvt_cmp_t cmp;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;
  int cyc_n = 0;
  int n;
  int tot;
  qrvt_top uut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_async(cmp), .fault_stop(fault), .gate_on(gate_on), .charger(charger));
  qrvt_frontend_model fe (.clock(clock), .lv(lv), .on_cyc(on_cyc), .ring_half(ring_half),
    .s1v(s1v), .gate_on(gate_on), .cmp(cmp));
  initial forever #2.5 clock = ~clock;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    // Request taken at the first edge, answer sampled at the second
    chk(n, 32'h2);
  endtask : wb
  // Least period and mask time expected from the package figures
  function automatic int exp_period(input bit h);
    return h ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
  endfunction : exp_period
  function automatic int exp_mask(input bit l);
    return l ? MASK_LONG_CYC : MASK_SHORT_CYC;
  endfunction : exp_mask
  // Waits for the gate, or the charger when c is set, to reach v
  task automatic wt(input bit c, input logic v, input int lim);
    n = 0;
    while ((c ? charger.charger_en : gate_on) !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk(c ? charger.charger_en : gate_on, v);
  endtask : wt
  task automatic meas(input int h, input int l, input bit ck);
    int p;
    int m;
    p = exp_period(h != 0);
    m = exp_mask(l != 0);
    wt(1'b0, 1'b0, 3000);
    tot = n;
    wt(1'b0, 1'b1, 4000);
    if (ck)
    begin
      chk(tot + n >= p, 1'b1);
      chk(n >= m, 1'b1);
      chk(tot + n <= (p > tot + m ? p : tot + m) + 4 * ring_half + 60, 1'b1);
    end
  endtask : meas
  always @(posedge clock)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 90000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(62886));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    wb(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(rd[7:0], 8'h81);
    chk(charger, {2'b10, CHARGE_NORMAL_UA});
    lv <= 4'h5;
    wt(1'b0, 1'b1, 20);
    chk(charger.charger_en, 1'b0);
    // Low rate before high, so the period never grows mid-cycle
    for (int i = 0; i < 4; i++)
    begin
      on_cyc <= 11'(100 + $urandom % 300);
      ring_half <= 11'(60 + $urandom % 100);
      s1v <= i[0];
      wb(1'b1, ADR_CTRL, {31'h0, i[1]});
      meas(i[1], i[0], 1'b0);
      meas(i[1], i[0], 1'b0);
      meas(i[1], i[0], 1'b1);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd[ST_LONG_BIT], i[0]);
    end
    wb(1'b0, ADR_SKIP, 32'h0);
    chk(rd[15:0] != 16'h0000, 1'b1);
    // Clear, then at most one skip can land before the read
    wb(1'b1, ADR_SKIP, 32'h0);
    wb(1'b0, ADR_SKIP, 32'h0);
    chk(rd[15:0] < 16'h0002, 1'b1);
    lv <= 4'h9;
    wt(1'b0, 1'b0, 8);
    repeat (20) @(posedge clock);
    chk(charger.charger_en, 1'b0);
    lv <= 4'h8;
    repeat (10) @(posedge clock);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk({rd[7], rd[4:0]}, 6'h08);
    lv <= 4'hB;
    wt(1'b1, 1'b1, 20);
    chk(charger, {2'b10, CHARGE_NORMAL_UA});
    lv <= 4'h5;
    wt(1'b0, 1'b1, 20);
    fault <= 1'b1;
    @(posedge clock);
    fault <= 1'b0;
    wt(1'b0, 1'b0, 4);
    lv <= 4'h3;
    wt(1'b1, 1'b1, 20);
    chk(charger, {2'b11, CHARGE_REDUCED_UA});
    lv <= 4'h5;
    wt(1'b0, 1'b1, 20);
    chk(charger.charge_reduced, 1'b1);
    meas(1, 1, 1'b0);
    @(posedge clock);
    chk(charger.charge_reduced, 1'b0);
    // Software fault request takes the same stop and slow restart path
    wb(1'b1, ADR_CTRL, 32'h3);
    wt(1'b0, 1'b0, 4);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h1);
    lv <= 4'h3;
    wt(1'b1, 1'b1, 20);
    chk(charger, {2'b11, CHARGE_REDUCED_UA});
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
